// >>> inc/lic_pkg.sv
// Constants and types for the laser I/O control and status block
// ============================================================
// How it works
// - Ready output and ready lamp high while enabled and able to lase.
// - Lasing output and lasing lamp high only while beam is emitted.
// - Over-temperature raises fault output and flashes ready lamp continuously.
// - Supply-fault output high while DC input voltage is out of limits.
// - Supply fault blinks power lamp twice, pauses half second, repeats.
// - Enable high enables; enable low blocks all commands to RF stage.
// - Five second wait after enable rises; commands blocked meanwhile.
// - Broadcast variant puts temperature serial signal on over-temperature pin.
package lic_pkg;
  // ============================================================
  // Timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned ENABLE_DELAY_S  = 5;
  localparam int unsigned ENABLE_DELAY_CYC = CLK_HZ * ENABLE_DELAY_S;
  localparam int unsigned BLINK_MS        = 125;
  localparam int unsigned PAUSE_MS        = 500;
  localparam int unsigned BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned PAUSE_CYC       = CLK_HZ / 1000 * PAUSE_MS;
  localparam int unsigned FLASH_MS        = 250;
  localparam int unsigned FLASH_CYC       = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned TIMER_W         = 28;
  localparam logic        SYNC_RESET      = 1'b0;

  // ============================================================
  // Power lamp pattern states
  typedef enum logic [2:0] {
    LIC_PAT_IDLE  = 3'b000,
    LIC_PAT_ON1   = 3'b001,
    LIC_PAT_OFF1  = 3'b010,
    LIC_PAT_ON2   = 3'b011,
    LIC_PAT_PAUSE = 3'b100
  } lic_pat_e;
endpackage : lic_pkg

// >>> inc/lic_sync_if.sv
// Interface carrying synchronised user inputs
`timescale 1ns/1ps
interface lic_sync_if;
  logic enable;
  logic command;
  modport src (output enable, output command);
  modport dst (input enable, input command);
endinterface : lic_sync_if

// >>> hw/lic_sync.sv
// Two-flop synchroniser for enable and command inputs
`timescale 1ns/1ps
module lic_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Raw inputs
  input  wire logic i_enable,
  input  wire logic i_command,
  // Synchronised outputs
  lic_sync_if.src   sync
);
  import lic_pkg::*;
  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] stab_reg;
  logic [1:0] stab_next;

  always_comb begin
    meta_next = {i_enable, i_command};
    stab_next = meta_reg;
  end

  // First stage is read only by the second
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= {SYNC_RESET, SYNC_RESET};
      stab_reg <= {SYNC_RESET, SYNC_RESET};
    end else begin
      meta_reg <= meta_next;
      stab_reg <= stab_next;
    end
  end

  assign sync.enable  = stab_reg[1];
  assign sync.command = stab_reg[0];
endmodule : lic_sync

// >>> hw/lic_top.sv
// Laser I/O control and status logic
`timescale 1ns/1ps
module lic_top #(
  parameter int unsigned ENABLE_DELAY = lic_pkg::ENABLE_DELAY_CYC,
  parameter int unsigned BLINK_LEN    = lic_pkg::BLINK_CYC,
  parameter int unsigned PAUSE_LEN    = lic_pkg::PAUSE_CYC,
  parameter int unsigned FLASH_LEN    = lic_pkg::FLASH_CYC,
  parameter bit          BROADCAST    = 1'b0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // User inputs
  input  wire logic i_enable,
  input  wire logic i_command,
  // Internal condition sensors
  input  wire logic i_over_temp,
  input  wire logic i_supply_fault,
  input  wire logic i_temp_broadcast,
  input  wire logic i_beam_on,
  // RF stage drive
  output logic      o_rf_command,
  // User status outputs
  output logic      o_ready,
  output logic      o_lasing,
  output logic      o_temp_out,
  output logic      o_supply_fault,
  // Front-panel lamps
  output logic      o_ready_lamp,
  output logic      o_lasing_lamp,
  output logic      o_power_lamp
);
  import lic_pkg::*;

  // ============================================================
  // Input synchronisation
  lic_sync_if sif ();
  lic_sync u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_enable  (i_enable),
    .i_command (i_command),
    .sync      (sif.src)
  );

  // ============================================================
  // Enable delay
  logic [TIMER_W-1:0] wait_reg;
  logic [TIMER_W-1:0] wait_next;
  logic               armed_reg;
  logic               armed_next;
  localparam logic [TIMER_W-1:0] DELAY_LAST = TIMER_W'(ENABLE_DELAY - 1);

  always_comb begin
    wait_next  = wait_reg;
    armed_next = armed_reg;
    if (!sif.enable) begin
      // Dropping enable mid-wait restarts the whole delay
      wait_next  = '0;
      armed_next = 1'b0;
    end else if (!armed_reg) begin
      if (wait_reg == DELAY_LAST) begin
        armed_next = 1'b1;
      end else begin
        wait_next = wait_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_reg  <= '0;
      armed_reg <= 1'b0;
    end else begin
      wait_reg  <= wait_next;
      armed_reg <= armed_next;
    end
  end

  // ============================================================
  // Status and command outputs
  logic outs_reg_rf;
  logic rf_next;
  logic rdy_reg;
  logic rdy_next;
  logic lase_reg;
  logic lase_next;
  logic temp_reg;
  logic temp_next;
  logic sup_reg;
  logic sup_next;

  always_comb begin
    // Commands reach RF only once armed; tickle and PWM pass unchanged
    rf_next   = armed_reg & sif.enable & sif.command;
    rdy_next  = armed_reg & sif.enable & ~i_over_temp;
    lase_next = i_beam_on & outs_reg_rf;
    temp_next = BROADCAST ? i_temp_broadcast : i_over_temp;
    sup_next  = i_supply_fault;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      outs_reg_rf <= 1'b0;
      rdy_reg     <= 1'b0;
      lase_reg    <= 1'b0;
      temp_reg    <= 1'b0;
      sup_reg     <= 1'b0;
    end else begin
      outs_reg_rf <= rf_next;
      rdy_reg     <= rdy_next;
      lase_reg    <= lase_next;
      temp_reg    <= temp_next;
      sup_reg     <= sup_next;
    end
  end

  // ============================================================
  // Lamp patterns
  lic_pat_e           pat_reg;
  lic_pat_e           pat_next;
  logic [TIMER_W-1:0] ptim_reg;
  logic [TIMER_W-1:0] ptim_next;
  logic [TIMER_W-1:0] ftim_reg;
  logic [TIMER_W-1:0] ftim_next;
  logic               flash_reg;
  logic               flash_next;
  logic               plamp_reg;
  logic               plamp_next;
  logic               rlamp_reg;
  logic               rlamp_next;

  function automatic logic [TIMER_W-1:0] last_of(input int unsigned len);
    last_of = TIMER_W'(len - 1);
  endfunction : last_of

  always_comb begin
    pat_next   = pat_reg;
    ptim_next  = ptim_reg + 1'b1;
    plamp_next = 1'b1;
    if (!i_supply_fault) begin
      pat_next  = LIC_PAT_IDLE;
      ptim_next = '0;
    end else begin
      case (pat_reg)
        LIC_PAT_IDLE: begin
          pat_next  = LIC_PAT_ON1;
          ptim_next = '0;
        end
        LIC_PAT_ON1, LIC_PAT_OFF1, LIC_PAT_ON2: begin
          if (ptim_reg == last_of(BLINK_LEN)) begin
            pat_next  = lic_pat_e'(pat_reg + 3'h1);
            ptim_next = '0;
          end
        end
        LIC_PAT_PAUSE: begin
          if (ptim_reg == last_of(PAUSE_LEN)) begin
            pat_next  = LIC_PAT_ON1;
            ptim_next = '0;
          end
        end
        default: begin
          pat_next  = LIC_PAT_IDLE;
          ptim_next = '0;
        end
      endcase
      // Lamp lit only in the blink phases of the pattern
      plamp_next = (pat_next == LIC_PAT_ON1) || (pat_next == LIC_PAT_ON2);
    end
  end

  always_comb begin
    ftim_next  = ftim_reg + 1'b1;
    flash_next = flash_reg;
    if (!i_over_temp) begin
      ftim_next  = '0;
      flash_next = 1'b1;
    end else if (ftim_reg == last_of(FLASH_LEN)) begin
      ftim_next  = '0;
      flash_next = ~flash_reg;
    end
    rlamp_next = i_over_temp ? flash_next : rdy_next;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat_reg   <= LIC_PAT_IDLE;
      ptim_reg  <= '0;
      ftim_reg  <= '0;
      flash_reg <= 1'b1;
      plamp_reg <= 1'b0;
      rlamp_reg <= 1'b0;
    end else begin
      pat_reg   <= pat_next;
      ptim_reg  <= ptim_next;
      ftim_reg  <= ftim_next;
      flash_reg <= flash_next;
      plamp_reg <= plamp_next;
      rlamp_reg <= rlamp_next;
    end
  end

  assign o_rf_command   = outs_reg_rf;
  assign o_ready        = rdy_reg;
  assign o_lasing       = lase_reg;
  assign o_temp_out     = temp_reg;
  assign o_supply_fault = sup_reg;
  assign o_ready_lamp   = rlamp_reg;
  assign o_lasing_lamp  = lase_reg;
  assign o_power_lamp   = plamp_reg;

  // ============================================================
  // Checks
  blocked_when_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !sif.enable |=> !o_rf_command) else $error("RF command while disabled");
  wait_blocks_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(sif.enable) |=> !o_rf_command [*2]) else $error("Command passed during wait");
  // Age of the synchronised enable, kept apart from the delay counter
  // so that the ready check does not lean on the logic it guards
  localparam logic [TIMER_W-1:0] READY_MIN = TIMER_W'(ENABLE_DELAY + 1);
  logic [TIMER_W-1:0] en_age_reg;
  logic [TIMER_W-1:0] en_age_next;

  always_comb begin
    en_age_next = '0;
    if (sif.enable) begin
      en_age_next = (en_age_reg == READY_MIN) ? en_age_reg : en_age_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_age_reg <= '0;
    end else begin
      en_age_reg <= en_age_next;
    end
  end

  ready_tracks_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_ready |-> (en_age_reg >= READY_MIN)) else $error("Ready before delay");
  ready_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !sif.enable |=> !o_ready) else $error("Ready while disabled");
  lasing_cause_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_lasing |-> $past(i_beam_on)) else $error("Lasing without beam");
  lasing_lamp_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_lasing_lamp == o_lasing) else $error("Lasing lamp mismatch");
  temp_out_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !BROADCAST |-> (o_temp_out == $past(i_over_temp))) else $error("Over-temp output wrong");
  supply_out_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_supply_fault == $past(i_supply_fault)) else $error("Supply fault output wrong");
  power_dark_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (pat_reg == LIC_PAT_PAUSE) |-> !o_power_lamp) else $error("Power lamp lit in pause");
  enable_restart_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(sif.enable) |=> (wait_reg == '0) && !armed_reg) else $error("Delay not restarted");
  command_pass_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_rf_command);
  pattern_loop_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    pat_reg == LIC_PAT_PAUSE ##1 pat_reg == LIC_PAT_ON1);
  flash_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_over_temp && $fell(o_ready_lamp));
endmodule : lic_top

// >>> verif/lic_ctrl_model.sv
// Partner model: user control system driving enable and command pins
`timescale 1ns/1ps
module lic_ctrl_model #(
  parameter int TICK_W   = 40,
  parameter int TICK_PER = 8000,
  parameter int PWM_PER  = 400,
  parameter int PWM_HI   = 200
) (
  // Clock and requests
  input  wire logic       i_clk,
  input  wire logic       i_en_req,
  input  wire logic [1:0] i_mode,
  // Pins toward the laser
  output logic            o_enable,
  output logic            o_command
);
  int cnt = 0;
  initial begin
    o_enable  = 1'b0;
    o_command = 1'b0;
  end
  // ============================================================
  // Off the falling edge; PWM_PER of 400 is the fastest rate allowed
  always @(negedge i_clk) begin
    o_enable <= i_en_req;
    cnt      <= (cnt + 1) % ((i_mode == 2'h2) ? PWM_PER : TICK_PER);
    case (i_mode)
      2'h1: o_command <= (cnt < TICK_W);
      2'h2: o_command <= (cnt < PWM_HI);
      default: o_command <= 1'b0;
    endcase
  end
endmodule : lic_ctrl_model

// >>> verif/tb_lic_top.sv
// Self-checking testbench for the laser I/O control and status block
`timescale 1ns/1ps
module tb_lic_top;
  localparam int DLY = 20;
  localparam int LIMIT = 6000;
  logic clk, rst_n, en_req, enable, command, ovt, sup, bc, beam, bc_temp;
  logic [1:0] mode;
  logic rf, rdy, lase, temp, supf, rdy_l, lase_l, pwr_l;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  // ============================================================
  // Clock, timeout and models
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end
  lic_ctrl_model i_ctrl (.i_clk(clk), .i_en_req(en_req), .i_mode(mode),
    .o_enable(enable), .o_command(command));
  lic_top #(.ENABLE_DELAY(DLY), .BLINK_LEN(4), .PAUSE_LEN(8), .FLASH_LEN(4)) i_dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_enable(enable), .i_command(command),
    .i_over_temp(ovt), .i_supply_fault(sup), .i_temp_broadcast(bc), .i_beam_on(beam),
    .o_rf_command(rf), .o_ready(rdy), .o_lasing(lase), .o_temp_out(temp),
    .o_supply_fault(supf), .o_ready_lamp(rdy_l), .o_lasing_lamp(lase_l),
    .o_power_lamp(pwr_l));
  lic_top #(.ENABLE_DELAY(DLY), .BROADCAST(1'b1)) i_dut_bc (
    .i_clk(clk), .i_reset_n(rst_n), .i_enable(enable), .i_command(command),
    .i_over_temp(ovt), .i_supply_fault(sup), .i_temp_broadcast(bc), .i_beam_on(beam),
    .o_rf_command(), .o_ready(), .o_lasing(), .o_temp_out(bc_temp),
    .o_supply_fault(), .o_ready_lamp(), .o_lasing_lamp(), .o_power_lamp());

  // ============================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %b", $time, m, got);
    end
  endtask : chk_bit
  task automatic chk_cnt(input int got, input int exp, input string m);
    n_compared++;
    if (got != exp) begin
      n_errors++;
      $display("BAD %0t %s count %0d", $time, m, got);
    end
  endtask : chk_cnt
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ============================================================
  // Scenarios
  task automatic t_delay();
    int hi = 0;
    en_req <= 1'b1;
    repeat (DLY) begin
      tick(1);
      hi += (rf === 1'b1);
    end
    chk_cnt(hi, 0, "early drive");
    tick(10);
    chk_bit(rdy, 1'b1, "ready");
    chk_bit(rdy_l, 1'b1, "ready lamp");
    hi = 0;
    repeat (400) begin
      tick(1);
      hi += (rf === 1'b1);
    end
    chk_cnt(hi, 200, "duty");
  endtask : t_delay
  task automatic t_drop();
    int hi = 0;
    en_req <= 1'b0;
    tick(8);
    chk_bit(rdy, 1'b0, "ready");
    chk_bit(rf, 1'b0, "rf off");
    en_req <= 1'b1;
    tick(10);
    en_req <= 1'b0;
    tick(2);
    en_req <= 1'b1;
    repeat (DLY) begin
      tick(1);
      hi += (rf === 1'b1) + (rdy === 1'b1);
    end
    chk_cnt(hi, 0, "restart");
    tick(10);
  endtask : t_drop
  task automatic t_lasing();
    logic prev;
    beam <= 1'b1;
    tick(2);
    repeat (400) begin
      prev = rf;
      tick(1);
      chk_bit(lase, prev, "lasing");
      chk_bit(lase_l, lase, "lase lamp");
    end
    beam <= 1'b0;
    tick(3);
    chk_bit(lase, 1'b0, "no beam");
  endtask : t_lasing
  task automatic t_temp();
    int tg = 0;
    logic p;
    ovt <= 1'b1;
    tick(3);
    chk_bit(temp, 1'b1, "overtemp");
    chk_bit(bc_temp, 1'b0, "bcast");
    p = rdy_l;
    repeat (40) begin
      tick(1);
      tg += (rdy_l !== p);
      p = rdy_l;
    end
    chk_cnt(tg, 10, "flash");
    ovt <= 1'b0;
    bc  <= 1'b1;
    tick(4);
    chk_bit(temp, 1'b0, "overtemp");
    chk_bit(bc_temp, 1'b1, "bcast");
    chk_bit(rdy, 1'b1, "ready back");
    chk_bit(rdy_l, 1'b1, "ready lamp");
  endtask : t_temp
  task automatic t_supply();
    int lit = 0;
    int run = 0;
    int mx = 0;
    sup <= 1'b1;
    tick(3);
    chk_bit(supf, 1'b1, "supply");
    repeat (40) begin
      tick(1);
      lit += (pwr_l === 1'b1);
      run = (pwr_l === 1'b0) ? run + 1 : 0;
      mx = (run > mx) ? run : mx;
    end
    chk_cnt(lit, 16, "blinks");
    chk_cnt(mx, 8, "pause");
    sup <= 1'b0;
    tick(4);
    chk_bit(supf, 1'b0, "supply");
    chk_bit(pwr_l, 1'b1, "power lamp");
  endtask : t_supply

  initial begin
    rst_n = 1'b0;
    en_req = 1'b0;
    mode = 2'h2;
    {ovt, sup, bc, beam} = 4'h0;
    tick(6);
    rst_n <= 1'b1;
    tick(3);
    chk_bit(rdy, 1'b0, "ready");
    t_delay();
    t_lasing();
    t_temp();
    t_supply();
    t_drop();
    mode <= 2'h1;
    t_lasing();
    conclude();
  end
endmodule : tb_lic_top
